// >>> rtl/deep_sync_fifo.sv
`timescale 1ns/1ps
module deep_sync_fifo #(
  parameter int AW = fifo_pkg::DEPTH_LOG2,
  parameter int DW = fifo_pkg::DATA_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic write_en,
  input wire logic [DW-1:0] write_data,
  input wire logic read_en,
  output logic [DW-1:0] read_data,
  output logic read_data_oe_n,
  input wire logic out_en_n,
  input wire logic retransmit_req,
  input wire logic offset_load,
  input wire logic [AW-1:0] almost_empty_offset,
  input wire logic [AW-1:0] almost_full_offset,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic replay_recovering
);
  localparam int RCW = fifo_pkg::REPLAY_CNT_W;
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
  localparam logic [AW-1:0] OFFSET_RESET = AW'(fifo_pkg::DEFAULT_OFFSET);
  localparam logic [RCW-1:0] RECOVERY = RCW'(fifo_pkg::REPLAY_RECOVERY_CYCLES);
  localparam int rec_max = fifo_pkg::REPLAY_RECOVERY_CYCLES;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [DW-1:0] read_data;
    logic [AW-1:0] ae_off;
    logic [AW-1:0] af_off;
    logic [RCW-1:0] replay_cnt;
  } core_state_type;

  core_state_type st;
  core_state_type next_st;
  logic [DW-1:0] mem [0:(1 << AW)-1];
  logic wr_ok;
  logic rd_ok;

  fifo_flag_if #(.AW(AW)) fl ();

  fifo_flag_unit #(.AW(AW)) u_flags (
    .core_clk(core_clk),
    .rst(rst),
    .fl(fl)
  );

  // Accept only while the flags allow it; replay freezes both sides
  assign wr_ok = write_en && fl.full_n && !retransmit_req;
  assign rd_ok = read_en && fl.empty_n && !retransmit_req;

  // Pointer, level, offset and replay bookkeeping
  always_comb begin
    next_st = st;
    if (wr_ok) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (rd_ok) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
      next_st.read_data = mem[st.rd_ptr];
    end
    case ({wr_ok, rd_ok})
      2'b10: next_st.count = st.count + 1'b1;
      2'b01: next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
    if (offset_load) begin
      next_st.ae_off = almost_empty_offset;
      next_st.af_off = almost_full_offset;
    end
    // Replay rewinds to the first word; a write pointer back at zero with words held means full
    if (retransmit_req) begin
      next_st.rd_ptr = '0;
      next_st.count = (st.wr_ptr == '0 && st.count != '0) ? DEPTH : {1'b0, st.wr_ptr};
      next_st.replay_cnt = RECOVERY;
    end else if (st.replay_cnt != '0) begin
      next_st.replay_cnt = st.replay_cnt - 1'b1;
    end
  end

  // Data word and replay count start low and offsets at their default; clocks may run meanwhile
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{wr_ptr: '0, rd_ptr: '0, count: '0, read_data: '0,
              ae_off: OFFSET_RESET, af_off: OFFSET_RESET, replay_cnt: '0};
    end else begin
      st <= next_st;
    end
  end

  // Storage is not reset; the level decides what is valid
  always_ff @(posedge core_clk) begin
    if (wr_ok) begin
      mem[st.wr_ptr] <= write_data;
    end
  end

  assign fl.next_level = next_st.count;
  assign fl.ae_off = st.ae_off;
  assign fl.af_off = st.af_off;

  assign read_data = st.read_data;
  assign read_data_oe_n = out_en_n;
  assign empty_flag_n = fl.empty_n;
  assign full_flag_n = fl.full_n;
  // Almost flags are only fresh once the edge after an offset load has passed
  assign almost_empty_flag_n = fl.ae_n;
  assign almost_full_flag_n = fl.af_n;
  assign replay_recovering = (st.replay_cnt != '0);

  // Reset leaves the word low and the buffer empty
  property p_reset_exit;
    @(posedge core_clk) $fell(rst) |-> (read_data == '0) && !empty_flag_n;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("bad state after reset");

  // Drive follows the enable pin; the word shown right after reset is all zeros
  property p_out_drive;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> (read_data_oe_n == out_en_n) && (!$fell(rst) || read_data == '0);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("outputs not low after reset");

  sequence s_leave_empty;
    !empty_flag_n ##1 empty_flag_n;
  endsequence

  property p_first_word;
    @(posedge core_clk) disable iff (rst)
      s_leave_empty ##0 (read_en && !retransmit_req)
        |=> (read_data == $past(mem[st.rd_ptr])) && (st.rd_ptr == $past(st.rd_ptr) + 1'b1);
  endproperty
  a_first_word: assert property (p_first_word) else $error("first word late");

  property p_empty_boundary;
    @(posedge core_clk) disable iff (rst)
      (!empty_flag_n && write_en && !retransmit_req) |=> empty_flag_n;
  endproperty
  a_empty_boundary: assert property (p_empty_boundary) else $error("empty not left");

  sequence s_replay_end;
    retransmit_req ##1 !retransmit_req;
  endsequence

  property p_replay_recover;
    @(posedge core_clk) disable iff (rst)
      s_replay_end |-> ##[0:rec_max] !replay_recovering;
  endproperty
  a_replay_recover: assert property (p_replay_recover) else $error("recovery too long");

  property p_replay_rewind;
    @(posedge core_clk) disable iff (rst)
      retransmit_req |=> (st.rd_ptr == '0) && replay_recovering;
  endproperty
  a_replay_rewind: assert property (p_replay_rewind) else $error("replay not rewound");

  property p_offset_default;
    @(posedge core_clk) $fell(rst) |-> (st.ae_off == OFFSET_RESET) && (st.af_off == OFFSET_RESET);
  endproperty
  a_offset_default: assert property (p_offset_default) else $error("offset default wrong");

  property p_write_store;
    @(posedge core_clk) disable iff (rst)
      (write_en && full_flag_n && !retransmit_req) |=>
        (st.wr_ptr == $past(st.wr_ptr) + 1'b1) && (mem[$past(st.wr_ptr)] == $past(write_data));
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");

  // An accepted read shows the word at the read pointer one edge later
  property p_read_present;
    @(posedge core_clk) disable iff (rst)
      (read_en && empty_flag_n && !retransmit_req) |=>
        (read_data == $past(mem[st.rd_ptr])) && (st.rd_ptr == $past(st.rd_ptr) + 1'b1);
  endproperty
  a_read_present: assert property (p_read_present) else $error("read word wrong");

  // A refused read keeps the shown word, so a slow reader sees no change
  property p_read_refused;
    @(posedge core_clk) disable iff (rst)
      (!empty_flag_n || retransmit_req) |=> $stable(read_data);
  endproperty
  a_read_refused: assert property (p_read_refused) else $error("read taken when refused");

  // A full buffer drops writes; replay freezes the write side
  property p_write_refused;
    @(posedge core_clk) disable iff (rst)
      (!full_flag_n || retransmit_req) |=> $stable(st.wr_ptr);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("write taken when refused");

  // Level and pointers must agree, or the flags would lie after a wrap
  property p_level_agree;
    @(posedge core_clk) disable iff (rst)
      1'b1 |-> (st.count <= DEPTH) && (st.count[AW-1:0] == st.wr_ptr - st.rd_ptr);
  endproperty
  a_level_agree: assert property (p_level_agree) else $error("level and pointers differ");

  // Outside recovery the end-point flags match the level held
  property p_flags_valid;
    @(posedge core_clk) disable iff (rst)
      !replay_recovering |-> (empty_flag_n == (st.count != '0)) &&
        (full_flag_n == (st.count != DEPTH));
  endproperty
  a_flags_valid: assert property (p_flags_valid) else $error("end flags stale");

  sequence s_recovery_done;
    replay_recovering ##1 !replay_recovering;
  endsequence

  // Almost flags use the offsets held before the edge that updated them
  property p_almost_fresh;
    @(posedge core_clk) disable iff (rst)
      s_recovery_done |-> (almost_empty_flag_n == (st.count > {1'b0, $past(st.ae_off)})) &&
        (almost_full_flag_n == (st.count < DEPTH - {1'b0, $past(st.af_off)}));
  endproperty
  a_almost_fresh: assert property (p_almost_fresh) else $error("almost flags stale");
endmodule : deep_sync_fifo

// >>> rtl/fifo_flag_if.sv
`timescale 1ns/1ps
interface fifo_flag_if #(
  parameter int AW = 16
);
  logic [AW:0] next_level;
  logic [AW-1:0] ae_off;
  logic [AW-1:0] af_off;
  logic empty_n;
  logic full_n;
  logic ae_n;
  logic af_n;
  modport core (output next_level, output ae_off, output af_off,
                input empty_n, input full_n, input ae_n, input af_n);
  modport flags (input next_level, input ae_off, input af_off,
                 output empty_n, output full_n, output ae_n, output af_n);
endinterface : fifo_flag_if

// >>> rtl/fifo_flag_unit.sv
`timescale 1ns/1ps
module fifo_flag_unit #(
  parameter int AW = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  fifo_flag_if.flags fl
);
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic ae_n;
    logic af_n;
  } flag_state_type;

  flag_state_type st;
  flag_state_type next_st;

  // Flags come from the level after this edge, so they never lag the pointers
  always_comb begin
    next_st = st;
    next_st.full_n = (fl.next_level != DEPTH);
    next_st.empty_n = (fl.next_level != '0);
    next_st.ae_n = (fl.next_level > {1'b0, fl.ae_off});
    next_st.af_n = (fl.next_level < (DEPTH - {1'b0, fl.af_off}));
  end

  // Empty and almost-empty asserted out of reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{empty_n: 1'b0, full_n: 1'b1, ae_n: 1'b0, af_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign fl.empty_n = st.empty_n;
  assign fl.full_n = st.full_n;
  assign fl.ae_n = st.ae_n;
  assign fl.af_n = st.af_n;

  property p_full_flag;
    @(posedge core_clk) disable iff (rst)
      1'b1 |=> (!fl.full_n == ($past(fl.next_level) == DEPTH));
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag wrong");

  property p_empty_flag;
    @(posedge core_clk) disable iff (rst)
      ($past(fl.next_level) == '0) |-> !fl.empty_n;
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong");

  property p_almost_empty;
    @(posedge core_clk) disable iff (rst)
      (fl.next_level <= {1'b0, fl.ae_off}) |=> !fl.ae_n;
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost empty wrong");

  property p_almost_full;
    @(posedge core_clk) disable iff (rst)
      (fl.next_level < DEPTH - {1'b0, fl.af_off}) |=> fl.af_n;
  endproperty
  a_almost_full: assert property (p_almost_full) else $error("almost full wrong");
endmodule : fifo_flag_unit

// >>> rtl/fifo_pkg.sv
package fifo_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH_LOG2 = 16;
  localparam int DEFAULT_OFFSET = 7;
  localparam int CLK_PERIOD_PS = 100000;
  localparam int EDGE_FLAG_SKEW_LIMIT_PS = 5000;
  localparam int PARTIAL_FLAG_SKEW_LIMIT_PS = 10000;
  localparam int REPLAY_PULSE_WIDTH_PS = 60000;
  localparam int REPLAY_RECOVERY_TIME_PS = 90000;
  // Least times round up, longest times round down, never below one cycle
  localparam int REPLAY_PULSE_CYCLES =
    ((REPLAY_PULSE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
    (REPLAY_PULSE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REPLAY_RECOVERY_CYCLES =
    (REPLAY_RECOVERY_TIME_PS / CLK_PERIOD_PS < 1) ? 1 :
    REPLAY_RECOVERY_TIME_PS / CLK_PERIOD_PS;
  // Flags are registered from the next level, so both skews fit in one cycle
  localparam int FLAG_SETTLE_CYCLES =
    (PARTIAL_FLAG_SKEW_LIMIT_PS > EDGE_FLAG_SKEW_LIMIT_PS) ?
    (PARTIAL_FLAG_SKEW_LIMIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS :
    (EDGE_FLAG_SKEW_LIMIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REPLAY_CNT_W = 8;
endpackage : fifo_pkg

// >>> sim/deep_sync_fifo_bench.sv
`timescale 1ns/1ps
module deep_sync_fifo_bench;
  localparam int AW = 4;
  localparam int DW = fifo_pkg::DATA_W;
  localparam int DEPTH = 1 << AW;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic want_wr = 1'h0;
  logic want_rd = 1'h0;
  logic want_rt = 1'h0;
  logic out_en_n = 1'h0;
  logic offset_load = 1'h0;
  logic [AW-1:0] ae_in = '0;
  logic [AW-1:0] af_in = '0;
  logic [DW-1:0] word = '0;
  logic write_en, read_en, retransmit_req, oe_n, recovering, e_n, f_n, ae_n, af_n;
  logic [DW-1:0] write_data, read_data, exp_data;
  logic [DW-1:0] mem [DEPTH];
  logic [5:0] exp_flags;
  logic [5:0] got_flags;
  logic [31:0] seed = 32'h8503aa2a;
  int n_errors = 0;
  int checked = 0;
  int level, wr_ptr, rd_ptr, ae_off, af_off, rec_left;
  bit skip, wr_ok, rd_ok;

  fifo_agent #(.DW(DW)) agent (.core_clk(core_clk), .want_wr(want_wr), .want_rd(want_rd),
    .want_rt(want_rt), .word(word), .write_en(write_en), .write_data(write_data),
    .read_en(read_en), .retransmit_req(retransmit_req));

  deep_sync_fifo #(.AW(AW)) uut (.core_clk(core_clk), .rst(rst), .write_en(write_en),
    .write_data(write_data), .read_en(read_en), .read_data(read_data),
    .read_data_oe_n(oe_n), .out_en_n(out_en_n), .retransmit_req(retransmit_req),
    .offset_load(offset_load), .almost_empty_offset(ae_in), .almost_full_offset(af_in),
    .empty_flag_n(e_n), .full_flag_n(f_n), .almost_empty_flag_n(ae_n),
    .almost_full_flag_n(af_n), .replay_recovering(recovering));

  // Every status output in one word, in the order of the model's flags
  assign got_flags = {e_n, f_n, ae_n, af_n, oe_n, recovering};

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  // Reference model; flags use the offsets held before this edge
  always @(posedge core_clk or posedge rst) begin
    skip = 0;
    if (rst) begin
      {level, wr_ptr, rd_ptr} = '0;
      ae_off = fifo_pkg::DEFAULT_OFFSET;
      af_off = fifo_pkg::DEFAULT_OFFSET;
      exp_data = '0;
      rec_left = 0;
    end else if (retransmit_req) begin
      // Rewind to the first word; a wrapped pointer with words held means full
      rd_ptr = 0;
      level = (wr_ptr % DEPTH == 0 && level != 0) ? DEPTH : wr_ptr % DEPTH;
      rec_left = fifo_pkg::REPLAY_RECOVERY_CYCLES;
      skip = 1;
    end else begin
      if (rec_left > 0) begin
        rec_left--;
      end
      wr_ok = write_en && level < DEPTH;
      rd_ok = read_en && level > 0;
      if (rd_ok) begin
        exp_data = mem[rd_ptr % DEPTH];
        rd_ptr++;
      end
      if (wr_ok) begin
        mem[wr_ptr % DEPTH] = write_data;
        wr_ptr++;
      end
      level = level + int'(wr_ok) - int'(rd_ok);
    end
    // Enable pin passes straight to drive control; recovery lasts its cycle count
    exp_flags = {level != 0, level != DEPTH, level > ae_off, level < DEPTH - af_off,
                 out_en_n, rec_left > 0};
    if (!rst && offset_load) begin
      ae_off = ae_in;
      af_off = af_in;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic cmp_flags(input logic [5:0] got, input logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flags

  task automatic cmp_data(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_data

  // One cycle: check settled outputs, then drive the next request
  task automatic step(input logic w, input logic r, input logic t);
    @(negedge core_clk);
    if (skip) begin
      cmp_flags(got_flags & 6'h01, exp_flags & 6'h01);
    end else begin
      cmp_flags(got_flags, exp_flags);
    end
    cmp_data(read_data, exp_data);
    seed = xs(seed);
    want_wr <= w;
    want_rd <= r;
    want_rt <= t;
    word <= seed[31:23];
    out_en_n <= seed[4];
    offset_load <= (seed[12:8] == 5'h00);
    ae_in <= seed[19:16];
    af_in <= seed[23:20];
  endtask : step

  task automatic final_report();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (16) step(1'h1, 1'h1, 1'h0);
    rst = 1'h0;
    // Write and read at once on empty, then a short burst
    repeat (3) step(1'h1, 1'h1, 1'h0);
    repeat (3) step(1'h0, 1'h0, 1'h0);
    step(1'h0, 1'h0, 1'h1);
    repeat (4) step(1'h0, 1'h1, 1'h0);
    // Write-heavy fill, read-heavy drain, then mixed traffic
    for (int i = 0; i < 600; i++) begin
      step(i < 200 ? seed[1:0] != 2'h0 : (i < 400 ? seed[1:0] == 2'h0 : seed[1]),
           i < 200 ? seed[3:2] == 2'h0 : (i < 400 ? seed[3:2] != 2'h0 : seed[2]), 1'h0);
    end
    // Replay after the write pointer has wrapped, then drain past empty
    step(1'h0, 1'h0, 1'h1);
    repeat (20) step(1'h0, 1'h1, 1'h0);
    // Reset again in mid-run while the clock keeps running
    rst = 1'h1;
    repeat (4) step(1'h1, 1'h1, 1'h0);
    rst = 1'h0;
    repeat (30) step(seed[0], seed[1], 1'h0);
    final_report();
  end

  // Run takes about 680 cycles
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule : deep_sync_fifo_bench

// >>> sim/fifo_agent.sv
`timescale 1ns/1ps
module fifo_agent #(
  parameter int DW = 9
) (
  input wire logic core_clk,
  input wire logic want_wr,
  input wire logic want_rd,
  input wire logic want_rt,
  input wire logic [DW-1:0] word,
  output logic write_en,
  output logic [DW-1:0] write_data,
  output logic read_en,
  output logic retransmit_req
);
  // Quiet start so the pins never float at time zero
  initial begin
    write_en = 1'h0;
    write_data = '0;
    read_en = 1'h0;
    retransmit_req = 1'h0;
  end
  // Change on the falling edge; idle data flips so a stale word is never mistaken
  always @(negedge core_clk) begin
    write_en <= want_wr;
    write_data <= want_wr ? word : ~write_data;
    read_en <= want_rd;
    retransmit_req <= want_rt;
  end
endmodule : fifo_agent
